// ===== verilog/psr_regs.sv
// Management-visible status, identifier and advertisement registers of the PHY.
//
// Operation
// - Link bit latches low on failure, stays low until status register is read.
// - Jabber bit latches high until status read or PHY reset.
// - Jabber is only recorded while running at ten megabit.
// - Extended-capability bit always reads one, ignores writes.
// - Both identifier registers together form one read-only identifier.
// - Upper identifier holds organizational ID bits 3..18 on bits 15..0.
// - Two top organizational ID bits appear in neither identifier register.
// - Lower identifier bits 15..10 hold organizational ID bits 19..24.
// - Lower identifier bits 9..4 hold the model number, MSB at 9.
// - Lower identifier bits 3..0 hold the revision, MSB at 3.
// - Advertisement word goes to negotiation; selector resets to 00001, writable.
// - Next-page bit always reads zero, writes ignored.
// - Acknowledge bit reads back the value driven by negotiation hardware.
// - Remote-fault bit writable, resets to zero, advertised to partner.
// - Flow-control bit writable, resets to zero, advertised to partner.
// - Four-pair bit permanently reads zero, ignores writes.
// - Four speed and duplex bits writable, each resets to one.
`timescale 1ns/1ps

module psr_regs
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        phy_soft_reset,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_rd,
  input  wire logic        mgmt_wr,
  input  wire logic [15:0] mgmt_wdata,
  input  wire logic        link_ok,
  input  wire logic        jabber_event,
  input  wire logic        speed_10,
  input  wire logic        an_ack,
  output logic [15:0]      mgmt_rdata_q,
  output logic             mgmt_rvalid_q,
  output logic [15:0]      adv_word_q,
  output logic             link_latch_q,
  output logic             jabber_latch_q
);

  // ---------------------------------------------------------------------------
  // Decode and read mux
  // ---------------------------------------------------------------------------
  logic        status_rd;
  logic        adv_wr;
  logic [15:0] adv_q;
  logic [15:0] status_word;
  logic [15:0] ident_upper;
  logic [15:0] ident_lower;
  logic [15:0] adv_view;
  logic [15:0] read_d;

  // Strobes qualified by the decoded address.
  assign status_rd = mgmt_rd && (mgmt_addr == psr_pkg::BASIC_LINK_STATUS_OFS);
  assign adv_wr    = mgmt_wr && (mgmt_addr == psr_pkg::AUTONEG_ADVERTISE_OFS);

  // Status word built from fixed ability bits and the two latches.
  always_comb
  begin
    status_word = psr_pkg::STAT_FIXED;
    status_word[psr_pkg::STAT_LINK_BIT]   = link_latch_q;
    status_word[psr_pkg::STAT_JABBER_BIT] = jabber_latch_q;
    status_word[psr_pkg::STAT_EXT_BIT]    = 1'b1;
  end

  // Identifier words are constants; the two top ID bits have no place in them.
  assign ident_upper = psr_pkg::ORG_ID_UPPER_BITS;
  assign ident_lower = {psr_pkg::ORG_ID_LOWER_BITS, psr_pkg::MODEL_NUMBER,
                        psr_pkg::MODEL_REVISION};

  // Advertisement view: fixed zeros and the acknowledge bit owned by negotiation.
  always_comb
  begin
    adv_view = adv_q;
    adv_view[psr_pkg::ADV_NEXT_PAGE_BIT] = 1'b0;
    adv_view[psr_pkg::ADV_T4_BIT]        = 1'b0;
    adv_view[psr_pkg::ADV_ACK_BIT]       = an_ack;
  end

  // Read mux; unmapped addresses read as zero.
  always_comb
  begin
    case (mgmt_addr)
      psr_pkg::BASIC_LINK_STATUS_OFS: read_d = status_word;
      psr_pkg::PHY_IDENT_UPPER_OFS:   read_d = ident_upper;
      psr_pkg::PHY_IDENT_LOWER_OFS:   read_d = ident_lower;
      psr_pkg::AUTONEG_ADVERTISE_OFS: read_d = adv_view;
      default:                        read_d = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Read data return
  // ---------------------------------------------------------------------------
  // Read data is captured one cycle after the strobe, with a valid pulse.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mgmt_rdata_q  <= 16'h0000;
      mgmt_rvalid_q <= 1'b0;
    end
    else
    begin
      mgmt_rvalid_q <= mgmt_rd;
      if (mgmt_rd)
      begin
        mgmt_rdata_q <= read_d;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Latched status bits
  // ---------------------------------------------------------------------------
  // Link latch: a failure wins over the re-arm done by a status read.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      link_latch_q <= 1'b0;
    end
    else if (phy_soft_reset || !link_ok)
    begin
      link_latch_q <= 1'b0;
    end
    else if (status_rd)
    begin
      link_latch_q <= 1'b1;
    end
  end

  // Jabber latch: a new event in a status-read cycle keeps the bit set.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      jabber_latch_q <= 1'b0;
    end
    else if (phy_soft_reset)
    begin
      jabber_latch_q <= 1'b0;
    end
    else if (jabber_event && speed_10)
    begin
      jabber_latch_q <= 1'b1;
    end
    else if (status_rd)
    begin
      jabber_latch_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Advertisement register
  // ---------------------------------------------------------------------------
  // Writable fields take the write data; read-only bits stay at zero in storage.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      adv_q <= psr_pkg::ADV_RESET;
    end
    else if (phy_soft_reset)
    begin
      adv_q <= psr_pkg::ADV_RESET;
    end
    else if (adv_wr)
    begin
      adv_q <= mgmt_wdata & psr_pkg::ADV_WRITE_MASK;
    end
  end

  // Word handed to the negotiation engine, registered for a clean output.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      adv_word_q <= psr_pkg::ADV_RESET;
    end
    else
    begin
      adv_word_q <= adv_view;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence link_drop_s;
    !link_ok;
  endsequence

  sequence status_read_s;
    status_rd ##1 mgmt_rvalid_q;
  endsequence

  link_fail_low_a: assert property (link_drop_s |=> !link_latch_q)
    else $error("Link latch not low after link failure.");

  link_hold_low_a: assert property (!link_latch_q && !status_rd |=> !link_latch_q)
    else $error("Link latch recovered without a status read.");

  jabber_set_a: assert property (jabber_event && speed_10 && !phy_soft_reset |=> jabber_latch_q)
    else $error("Jabber latch not set by jabber at ten megabit.");

  jabber_fast_a: assert property (!jabber_latch_q && !speed_10 |=> !jabber_latch_q)
    else $error("Jabber latch set while not at ten megabit.");

  read_then_clear_a: assert property (status_rd && jabber_latch_q && !(jabber_event && speed_10)
                                      && !phy_soft_reset |-> status_read_s
                                      ##0 mgmt_rdata_q[psr_pkg::STAT_JABBER_BIT] && !jabber_latch_q)
    else $error("Status read did not return then clear jabber.");

  ext_cap_a: assert property (mgmt_rvalid_q && $past(mgmt_addr) == psr_pkg::BASIC_LINK_STATUS_OFS
                              |-> mgmt_rdata_q[psr_pkg::STAT_EXT_BIT])
    else $error("Extended capability bit read as zero.");

  ident_lower_a: assert property (mgmt_rd && mgmt_addr == psr_pkg::PHY_IDENT_LOWER_OFS
                                  |=> mgmt_rdata_q == {psr_pkg::ORG_ID_LOWER_BITS,
                                  psr_pkg::MODEL_NUMBER, psr_pkg::MODEL_REVISION})
    else $error("Lower identifier read wrong.");

  ident_upper_a: assert property (mgmt_rd && mgmt_addr == psr_pkg::PHY_IDENT_UPPER_OFS
                                  |=> mgmt_rdata_q == psr_pkg::ORG_ID_UPPER_BITS)
    else $error("Upper identifier read wrong.");

  adv_fixed_zero_a: assert property (!adv_word_q[psr_pkg::ADV_NEXT_PAGE_BIT]
                                     && !adv_word_q[psr_pkg::ADV_T4_BIT])
    else $error("Next-page or four-pair bit advertised.");

  adv_ack_follow_a: assert property (##1 adv_word_q[psr_pkg::ADV_ACK_BIT] == $past(an_ack))
    else $error("Acknowledge bit does not follow negotiation.");

  // A write lands in storage at once and reaches the advertised word one edge later.
  sequence adv_store_s;
    adv_wr && !phy_soft_reset
    ##1 (adv_q & psr_pkg::ADV_WRITE_MASK) == ($past(mgmt_wdata) & psr_pkg::ADV_WRITE_MASK);
  endsequence

  adv_write_a: assert property (adv_wr && !phy_soft_reset |-> adv_store_s
                                ##1 (adv_word_q & psr_pkg::ADV_WRITE_MASK)
                                == ($past(mgmt_wdata, 2) & psr_pkg::ADV_WRITE_MASK))
    else $error("Advertisement write not taken.");

  // Every read strobe is answered by exactly one valid pulse.
  read_valid_a: assert property (mgmt_rd |=> mgmt_rvalid_q)
    else $error("Read strobe not answered by valid.");

  valid_single_a: assert property (!mgmt_rd |=> !mgmt_rvalid_q)
    else $error("Valid pulse without a read strobe.");

  // Read data holds between reads so a slow master can still take it.
  rdata_hold_a: assert property (!mgmt_rd |=> $stable(mgmt_rdata_q))
    else $error("Read data changed without a read.");

  unmapped_zero_a: assert property (mgmt_rd && (mgmt_addr < psr_pkg::BASIC_LINK_STATUS_OFS
                                    || mgmt_addr > psr_pkg::AUTONEG_ADVERTISE_OFS)
                                    |=> mgmt_rdata_q == 16'h0000)
    else $error("Unmapped address read as nonzero.");

  // Soft reset clears both latched bits.
  soft_clear_a: assert property (phy_soft_reset |=> !link_latch_q && !jabber_latch_q)
    else $error("Soft reset left a latched bit set.");

  // A status read with the link up re-arms the link bit, and nothing else raises it.
  link_rearm_a: assert property (status_rd && link_ok && !phy_soft_reset |=> link_latch_q)
    else $error("Link bit not re-armed by a status read.");

  link_rise_read_a: assert property ($rose(link_latch_q) |-> $past(status_rd))
    else $error("Link bit rose without a status read.");

  // A status read without a new jabber event clears the jabber bit.
  jabber_clear_a: assert property (status_rd && !(jabber_event && speed_10) |=> !jabber_latch_q)
    else $error("Jabber bit not cleared by a status read.");

  // A status read returns the latch values from before the read.
  sequence status_capture_s;
    status_rd ##1 (mgmt_rdata_q[psr_pkg::STAT_LINK_BIT] == $past(link_latch_q)
                   && mgmt_rdata_q[psr_pkg::STAT_JABBER_BIT] == $past(jabber_latch_q));
  endsequence

  status_value_a: assert property (status_rd |-> status_capture_s)
    else $error("Status read did not return the latched bits.");

  // The status word outside the two latches is fixed.
  status_fixed_a: assert property (mgmt_rvalid_q && $past(mgmt_addr) == psr_pkg::BASIC_LINK_STATUS_OFS
                                   |-> (mgmt_rdata_q | 16'h0006) == (psr_pkg::STAT_FIXED | 16'h0006))
    else $error("Fixed status bits read wrong.");

  // Advertisement read shows fixed zeros and the negotiation-owned acknowledge.
  adv_read_fixed_a: assert property (mgmt_rd && mgmt_addr == psr_pkg::AUTONEG_ADVERTISE_OFS
                                     |=> !mgmt_rdata_q[psr_pkg::ADV_NEXT_PAGE_BIT]
                                     && !mgmt_rdata_q[psr_pkg::ADV_T4_BIT]
                                     && mgmt_rdata_q[psr_pkg::ADV_ACK_BIT] == $past(an_ack))
    else $error("Advertisement read shows a fixed bit wrong.");

  // Storage changes only by a write or a soft reset.
  adv_store_hold_a: assert property (!adv_wr && !phy_soft_reset |=> $stable(adv_q))
    else $error("Advertisement changed without a write.");

endmodule // psr_regs

// ===== verilog/psr_pkg.sv
// Package with register offsets, field positions and reset values of the PHY register subset.
package psr_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets on the management port
  // ---------------------------------------------------------------------------
  localparam logic [4:0] BASIC_LINK_STATUS_OFS = 5'h01;
  localparam logic [4:0] PHY_IDENT_UPPER_OFS   = 5'h02;
  localparam logic [4:0] PHY_IDENT_LOWER_OFS   = 5'h03;
  localparam logic [4:0] AUTONEG_ADVERTISE_OFS = 5'h04;

  // ---------------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------------
  localparam int         STAT_LINK_BIT   = 2;
  localparam int         STAT_JABBER_BIT = 1;
  localparam int         STAT_EXT_BIT    = 0;
  // Permanent ability bits: TX full/half, 10 full/half, negotiation ability, extended registers.
  localparam logic [15:0] STAT_FIXED     = 16'h7809;

  // ---------------------------------------------------------------------------
  // Identifier values (arbitrary neutral values)
  // ---------------------------------------------------------------------------
  // Organizational ID bits 3..18, bit 3 on register bit 15; value is arbitrary.
  localparam logic [15:0] ORG_ID_UPPER_BITS = 16'h5a3c;
  // Organizational ID bits 19..24, bit 19 on register bit 15; value is arbitrary.
  localparam logic [5:0]  ORG_ID_LOWER_BITS = 6'h15;
  // Model number and revision; values are arbitrary.
  localparam logic [5:0]  MODEL_NUMBER      = 6'h2a;
  localparam logic [3:0]  MODEL_REVISION    = 4'h3;
  localparam int          IDL_ORG_LSB       = 10;
  localparam int          IDL_MODEL_LSB     = 4;
  localparam int          IDL_REV_LSB       = 0;

  // ---------------------------------------------------------------------------
  // Advertisement register fields
  // ---------------------------------------------------------------------------
  localparam int          ADV_NEXT_PAGE_BIT = 15;
  localparam int          ADV_ACK_BIT       = 14;
  localparam int          ADV_RF_BIT        = 13;
  localparam int          ADV_FC_BIT        = 10;
  localparam int          ADV_T4_BIT        = 9;
  localparam logic [15:0] ADV_WRITE_MASK    = 16'h3dff;
  localparam logic [15:0] ADV_RESET         = 16'h01e1;

endpackage : psr_pkg

// ===== test/psr_mgmt_master.sv
// Management master model that issues whole-word reads and writes.
`timescale 1ns/1ps
module psr_mgmt_master
(
  input  wire logic        clock,
  input  wire logic [15:0] mgmt_rdata_q,
  input  wire logic        mgmt_rvalid_q,
  output logic [4:0]       mgmt_addr,
  output logic             mgmt_rd,
  output logic             mgmt_wr,
  output logic [15:0]      mgmt_wdata
);
  // Strobes start low so no request is seen during reset.
  initial
  begin
    mgmt_addr  = 5'h1f;
    mgmt_rd    = 1'b0;
    mgmt_wr    = 1'b0;
    mgmt_wdata = 16'h0000;
  end

  // Writes one word; the ack bit and reserved bits are always sent as zero.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    mgmt_addr  = a;
    mgmt_wdata = d & ~16'h5800;
    mgmt_wr    = 1'b1;
    @(negedge clock);
    mgmt_wr    = 1'b0;
    mgmt_addr  = ~a;
    mgmt_wdata = ~mgmt_wdata;
  endtask

  // Reads one word; data and valid are taken one cycle after the strobe.
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(negedge clock);
    mgmt_addr = a;
    mgmt_rd   = 1'b1;
    @(negedge clock);
    mgmt_rd   = 1'b0;
    mgmt_addr = ~a;
    d         = mgmt_rdata_q;
    v         = mgmt_rvalid_q;
  endtask
endmodule // psr_mgmt_master

// ===== test/phy_status_id_advert_regs_tb.sv
// Self-checking testbench of the PHY status, identifier and advertisement registers.
`timescale 1ns/1ps
module phy_status_id_advert_regs_tb;
  logic        clock, rstn, phy_soft_reset, link_ok, jabber_event, speed_10, an_ack;
  logic [4:0]  mgmt_addr;
  logic        mgmt_rd, mgmt_wr, mgmt_rvalid_q, link_latch_q, jabber_latch_q;
  logic [15:0] mgmt_wdata, mgmt_rdata_q, adv_word_q;
  int          n_mismatch  = 0;
  int          checks_done = 0;

  psr_regs dut (.clock(clock), .rstn(rstn), .phy_soft_reset(phy_soft_reset), .mgmt_addr(mgmt_addr),
    .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .link_ok(link_ok),
    .jabber_event(jabber_event), .speed_10(speed_10), .an_ack(an_ack), .mgmt_rdata_q(mgmt_rdata_q),
    .mgmt_rvalid_q(mgmt_rvalid_q), .adv_word_q(adv_word_q), .link_latch_q(link_latch_q),
    .jabber_latch_q(jabber_latch_q));
  psr_mgmt_master mm (.clock(clock), .mgmt_rdata_q(mgmt_rdata_q), .mgmt_rvalid_q(mgmt_rvalid_q),
    .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata));

  // Free-running clock of 10 ns.
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Reads a register and checks both the data and its valid pulse.
  task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    mm.rd(a, d, v);
    chk({nm, " valid"}, {15'h0000, v}, 16'h0001);
    chk(nm, d, e);
  endtask

  // Expected status word for given latch values.
  function automatic logic [15:0] sw(input logic l, input logic j);
    return psr_pkg::STAT_FIXED | {13'h0000, l, j, 1'b0};
  endfunction

  // One-cycle pulse on the jabber input or the soft reset input.
  task automatic pulse(input logic jab);
    @(negedge clock);
    if (jab)
    begin
      jabber_event = 1'b1;
    end
    else
    begin
      phy_soft_reset = 1'b1;
    end
    @(negedge clock);
    jabber_event   = 1'b0;
    phy_soft_reset = 1'b0;
  endtask

  // Reset values of every register and an unmapped address.
  task automatic t_reset;
    rchk("stat", 5'h01, sw(1'b0, 1'b0));
    rchk("id1", 5'h02, psr_pkg::ORG_ID_UPPER_BITS);
    rchk("id2", 5'h03, {psr_pkg::ORG_ID_LOWER_BITS, psr_pkg::MODEL_NUMBER, psr_pkg::MODEL_REVISION});
    rchk("adv", 5'h04, psr_pkg::ADV_RESET);
    rchk("none", 5'h05, 16'h0000);
    chk("word", adv_word_q, psr_pkg::ADV_RESET);
    $display("test reset done");
  endtask

  // Link bit stays low after a failure until the status is read.
  task automatic t_link;
    link_ok = 1'b1;
    rchk("stat", 5'h01, sw(1'b0, 1'b0));
    rchk("stat", 5'h01, sw(1'b1, 1'b0));
    @(negedge clock);
    link_ok = 1'b0;
    @(negedge clock);
    link_ok = 1'b1;
    chk("llatch", {15'h0000, link_latch_q}, 16'h0000);
    rchk("stat", 5'h01, sw(1'b0, 1'b0));
    mm.wr(5'h01, 16'h0000);
    rchk("stat", 5'h01, sw(1'b1, 1'b0));
    $display("test link done");
  endtask

  // Jabber latches only at ten megabit and clears on read or soft reset.
  task automatic t_jabber;
    pulse(1'b1);
    rchk("stat", 5'h01, sw(1'b1, 1'b0));
    speed_10 = 1'b1;
    pulse(1'b1);
    chk("jlatch", {15'h0000, jabber_latch_q}, 16'h0001);
    rchk("stat", 5'h01, sw(1'b1, 1'b1));
    rchk("stat", 5'h01, sw(1'b1, 1'b0));
    // A jabber event in the same cycle as a status read sets the bit; the read returns the old zero.
    fork
      rchk("stat", 5'h01, sw(1'b1, 1'b0));
      pulse(1'b1);
    join
    rchk("stat", 5'h01, sw(1'b1, 1'b1));
    pulse(1'b1);
    pulse(1'b0);
    rchk("stat", 5'h01, sw(1'b0, 1'b0));
    $display("test jabber done");
  endtask

  // Writable and fixed advertisement bits, ack follow and soft reset.
  task automatic t_adv;
    mm.wr(5'h04, 16'hffff);
    rchk("adv", 5'h04, 16'hffff & ~16'h5800 & psr_pkg::ADV_WRITE_MASK);
    chk("word", adv_word_q, 16'hffff & ~16'h5800 & psr_pkg::ADV_WRITE_MASK);
    mm.wr(5'h04, 16'h0000);
    rchk("adv", 5'h04, 16'h0000);
    an_ack = 1'b1;
    rchk("adv", 5'h04, 16'h4000);
    chk("word", adv_word_q, 16'h4000);
    mm.wr(5'h02, 16'h0000);
    rchk("id1", 5'h02, psr_pkg::ORG_ID_UPPER_BITS);
    pulse(1'b0);
    rchk("adv", 5'h04, psr_pkg::ADV_RESET | 16'h4000);
    $display("test advertise done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog against a hung run.
  initial
  begin
    #20000;
    n_mismatch++;
    give_verdict;
  end

  // Main sequence: reset for four cycles, then the tests.
  initial
  begin
    {phy_soft_reset, link_ok, jabber_event, speed_10, an_ack} = 5'h00;
    rstn = 1'b0;
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    t_reset;
    t_link;
    t_jabber;
    t_adv;
    give_verdict;
  end
endmodule // phy_status_id_advert_regs_tb
